// file: hdl/smd_pkg.sv
// package: constants, register map and carrier types of the memory address decoder
package smd_pkg;

  // address map boundaries
  localparam logic [35:0] SMD_4G_BASE      = 36'h1_0000_0000;
  localparam logic [31:0] SMD_DOS_LOW_END  = 32'h0007_FFFF;
  localparam logic [31:0] SMD_DOS_HI_END   = 32'h0009_FFFF;
  localparam logic [31:0] SMD_VGA_BASE     = 32'h000A_0000;
  localparam logic [31:0] SMD_VGA_END      = 32'h000B_FFFF;
  localparam logic [31:0] SMD_EXP_BASE     = 32'h000C_0000;
  localparam logic [31:0] SMD_EXP_END      = 32'h000D_FFFF;
  localparam logic [31:0] SMD_EBIOS_BASE   = 32'h000E_0000;
  localparam logic [31:0] SMD_EBIOS_END    = 32'h000E_FFFF;
  localparam logic [31:0] SMD_SBIOS_END    = 32'h000F_FFFF;
  localparam logic [31:0] SMD_EXT_BASE     = 32'h0010_0000;
  localparam logic [31:0] SMD_IOAPIC_BASE  = 32'hFEC0_0000;
  localparam logic [31:0] SMD_GAP_BASE     = 32'hFEC0_FFFF;
  localparam logic [31:0] SMD_HBIOS_BASE   = 32'hFFE0_0000;

  // segment geometry: 16 KB segments selected by address bits [16:14]
  localparam int SMD_SEG_LSB      = 14;
  localparam int SMD_SEG_SEL_W    = 3;
  localparam int SMD_EXP_SEGS     = 8;
  localparam int SMD_EBIOS_SEGS   = 4;
  localparam int SMD_ATTR_W       = 2;
  localparam int SMD_ATTR_RD      = 0;
  localparam int SMD_ATTR_WR      = 1;

  // 1 MB granule windows compare address bits [31:20]
  localparam int SMD_GRAN_LSB     = 20;
  localparam int SMD_GRAN_W       = 12;

  // register offsets (byte addresses)
  localparam logic [7:0] SMD_REG_CTRL    = 8'h00;
  localparam logic [7:0] SMD_REG_TOM     = 8'h04;
  localparam logic [7:0] SMD_REG_HOLE    = 8'h08;
  localparam logic [7:0] SMD_REG_AGPWIN  = 8'h0C;
  localparam logic [7:0] SMD_REG_AGPPREF = 8'h10;
  localparam logic [7:0] SMD_REG_APERT   = 8'h14;
  localparam logic [7:0] SMD_REG_SEGATTR = 8'h18;
  localparam logic [7:0] SMD_REG_STATUS  = 8'h1C;

  // field positions
  localparam int SMD_CTRL_FIXED_HOLE = 0;
  localparam int SMD_CTRL_VGA_AGP    = 1;
  localparam int SMD_CTRL_EXT_HOLE   = 2;
  localparam int SMD_CTRL_W          = 3;
  localparam int SMD_PAIR_LO_LSB     = 0;
  localparam int SMD_PAIR_HI_LSB     = 16;
  localparam int SMD_SEG_EXP_LSB     = 0;
  localparam int SMD_SEG_EBIOS_LSB   = 16;
  localparam int SMD_SEG_SBIOS_LSB   = 24;
  localparam int SMD_SEG_W           = 26;

  // reset values
  localparam logic [SMD_CTRL_W-1:0] SMD_CTRL_RST = 3'h0;
  localparam logic [SMD_SEG_W-1:0]  SMD_SEG_RST  = 26'h0;
  localparam logic [11:0]           SMD_ZERO12   = 12'h000;

  typedef enum logic [1:0] {SMD_SRC_HOST, SMD_SRC_PCI, SMD_SRC_AGP} smd_src_t;

  typedef enum logic [2:0] {
    SMD_DST_NONE, SMD_DST_DRAM, SMD_DST_PCI, SMD_DST_AGP, SMD_DST_TERM
  } smd_dst_t;

  typedef struct packed {
    logic [35:0] addr;
    logic        write;
    smd_src_t    src;
    logic        dac;
  } smd_req_t;

  typedef struct packed {
    smd_dst_t    dest;
    logic        read_zero;
    logic        discard;
    logic [31:0] addr;
  } smd_rsp_t;

endpackage

// file: hdl/smd_decoder.sv
// memory address decoder: classifies each memory access and names its destination
//
// Behaviour
// - host accesses at or above 4 GB terminated internally
// - host writes above 4 GB: data discarded
// - host reads above 4 GB return zeros
// - dual address cycles never claimed
// - gaps, video, holes, windows go to PCI
// - DRAM under a hole is never relocated
// - first 512 KB always DRAM
// - 512-640 KB DRAM unless fixed hole set
// - video range ignores attributes, PCI or AGP
// - only PCI-to-AGP memory writes cross bridges
// - eight expansion segments with four attribute states
// - four extended firmware segments, read/write attributes
// - system firmware segment resets disabled, goes PCI
// - 1 MB to top of memory is DRAM
// - AGP window and aperture override default PCI
// - interrupt controller range routed to PCI
// - gap below high firmware PCI when above top of memory
// - top 2 MB firmware routed to PCI
// - two AGP base/limit pairs forward to AGP
// - windows compare A[31:20], inclusive 1 MB granule
// - VGA bit sends video range to AGP
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module smd_decoder
  import smd_pkg::*;
#(
  parameter logic [11:0] TOM_RST = 12'h010
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [31:0]            reg_rdata,
  // access to classify
  input  wire logic              req_valid,
  input  wire smd_pkg::smd_req_t req,
  // routing decision, one cycle after the request
  output logic                   rsp_valid,
  output smd_pkg::smd_rsp_t      rsp
);
  import smd_pkg::*;

  logic [SMD_CTRL_W-1:0] ctrl_r;
  logic [11:0]           tom_r;
  logic [11:0]           hole_base_r;
  logic [11:0]           hole_limit_r;
  logic [11:0]           agp_window_base_r;
  logic [11:0]           agp_window_limit_r;
  logic [11:0]           agp_prefetch_window_base_r;
  logic [11:0]           agp_prefetch_window_limit_r;
  logic [11:0]           apert_base_r;
  logic [11:0]           apert_mask_r;
  logic [SMD_SEG_W-1:0]  seg_attr_r;
  smd_dst_t              last_dest_r;
  logic                  last_zero_r;
  smd_rsp_t              rsp_nxt;

  logic fixed_dram_hole_control;
  logic bridge_control_vga;
  logic ext_hole_en;
  assign fixed_dram_hole_control = ctrl_r[SMD_CTRL_FIXED_HOLE];
  assign bridge_control_vga      = ctrl_r[SMD_CTRL_VGA_AGP];
  assign ext_hole_en             = ctrl_r[SMD_CTRL_EXT_HOLE];

  // inclusive base/limit match on a 1 MB granule
  function automatic logic in_window(input logic [31:0] a, input logic [11:0] base,
                                     input logic [11:0] limit);
    logic [11:0] g;
    g = a[31:SMD_GRAN_LSB];
    return (g >= base) && (g <= limit);
  endfunction

  // segment attribute decides DRAM versus PCI; a disabled segment is never DRAM
  function automatic logic seg_dram(input logic [SMD_ATTR_W-1:0] attr, input logic wr);
    return wr ? attr[SMD_ATTR_WR] : attr[SMD_ATTR_RD];
  endfunction

  // register writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r                      <= SMD_CTRL_RST;
      tom_r                       <= TOM_RST;
      hole_base_r                 <= SMD_ZERO12;
      hole_limit_r                <= SMD_ZERO12;
      agp_window_base_r           <= SMD_ZERO12;
      agp_window_limit_r          <= SMD_ZERO12;
      agp_prefetch_window_base_r  <= SMD_ZERO12;
      agp_prefetch_window_limit_r <= SMD_ZERO12;
      apert_base_r                <= SMD_ZERO12;
      apert_mask_r                <= SMD_ZERO12;
      seg_attr_r                  <= SMD_SEG_RST;
    end else if (reg_wr) begin
      if (reg_addr == SMD_REG_CTRL) begin
        ctrl_r <= reg_wdata[SMD_CTRL_W-1:0];
      end else if (reg_addr == SMD_REG_TOM) begin
        tom_r <= reg_wdata[SMD_PAIR_LO_LSB +: SMD_GRAN_W];
      end else if (reg_addr == SMD_REG_HOLE) begin
        hole_base_r  <= reg_wdata[SMD_PAIR_LO_LSB +: SMD_GRAN_W];
        hole_limit_r <= reg_wdata[SMD_PAIR_HI_LSB +: SMD_GRAN_W];
      end else if (reg_addr == SMD_REG_AGPWIN) begin
        agp_window_base_r  <= reg_wdata[SMD_PAIR_LO_LSB +: SMD_GRAN_W];
        agp_window_limit_r <= reg_wdata[SMD_PAIR_HI_LSB +: SMD_GRAN_W];
      end else if (reg_addr == SMD_REG_AGPPREF) begin
        agp_prefetch_window_base_r  <= reg_wdata[SMD_PAIR_LO_LSB +: SMD_GRAN_W];
        agp_prefetch_window_limit_r <= reg_wdata[SMD_PAIR_HI_LSB +: SMD_GRAN_W];
      end else if (reg_addr == SMD_REG_APERT) begin
        apert_base_r <= reg_wdata[SMD_PAIR_LO_LSB +: SMD_GRAN_W];
        apert_mask_r <= reg_wdata[SMD_PAIR_HI_LSB +: SMD_GRAN_W];
      end else if (reg_addr == SMD_REG_SEGATTR) begin
        seg_attr_r <= reg_wdata[SMD_SEG_W-1:0];
      end
    end
  end

  // register reads, data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      if (reg_addr == SMD_REG_CTRL) begin
        reg_rdata <= {29'h0, ctrl_r};
      end else if (reg_addr == SMD_REG_TOM) begin
        reg_rdata <= {20'h0, tom_r};
      end else if (reg_addr == SMD_REG_HOLE) begin
        reg_rdata <= {4'h0, hole_limit_r, 4'h0, hole_base_r};
      end else if (reg_addr == SMD_REG_AGPWIN) begin
        reg_rdata <= {4'h0, agp_window_limit_r, 4'h0, agp_window_base_r};
      end else if (reg_addr == SMD_REG_AGPPREF) begin
        reg_rdata <= {4'h0, agp_prefetch_window_limit_r, 4'h0, agp_prefetch_window_base_r};
      end else if (reg_addr == SMD_REG_APERT) begin
        reg_rdata <= {4'h0, apert_mask_r, 4'h0, apert_base_r};
      end else if (reg_addr == SMD_REG_SEGATTR) begin
        reg_rdata <= {6'h0, seg_attr_r};
      end else if (reg_addr == SMD_REG_STATUS) begin
        reg_rdata <= {28'h0, last_zero_r, last_dest_r};
      end else begin
        reg_rdata <= 32'h0;
      end
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // address classification
  logic [31:0]                  a32;
  logic [SMD_SEG_SEL_W-1:0]     seg_idx;
  logic                         agp_hit;
  logic                         apert_hit;
  logic                         hole_hit;
  logic                         below_tom;
  logic                         exp_dram;
  logic                         ebios_dram;
  logic                         sbios_dram;
  smd_dst_t                     map_dst;

  assign a32       = req.addr[31:0];
  assign seg_idx   = a32[SMD_SEG_LSB +: SMD_SEG_SEL_W];
  assign agp_hit   = in_window(a32, agp_window_base_r, agp_window_limit_r) ||
                     in_window(a32, agp_prefetch_window_base_r,
                               agp_prefetch_window_limit_r);
  // aperture is naturally aligned: mask bits clear the size-dependent low granules
  assign apert_hit = ((a32[31:SMD_GRAN_LSB] & ~apert_mask_r) ==
                      (apert_base_r & ~apert_mask_r));
  assign hole_hit  = ext_hole_en && in_window(a32, hole_base_r, hole_limit_r);
  assign below_tom = a32[31:SMD_GRAN_LSB] < tom_r;

  // per-segment attribute lookup, indexed by segment number
  always_comb begin
    exp_dram   = seg_dram(seg_attr_r[SMD_SEG_EXP_LSB + seg_idx*SMD_ATTR_W +: SMD_ATTR_W],
                          req.write);
    ebios_dram = seg_dram(seg_attr_r[SMD_SEG_EBIOS_LSB +
                                     seg_idx[1:0]*SMD_ATTR_W +: SMD_ATTR_W],
                          req.write);
    sbios_dram = seg_dram(seg_attr_r[SMD_SEG_SBIOS_LSB +: SMD_ATTR_W], req.write);
  end

  // global map below 4 GB; compatibility and main-memory checks come first
  always_comb begin
    map_dst = SMD_DST_PCI;
    if (a32 <= SMD_DOS_LOW_END) begin
      map_dst = SMD_DST_DRAM;
    end else if (a32 <= SMD_DOS_HI_END) begin
      map_dst = fixed_dram_hole_control ? SMD_DST_PCI : SMD_DST_DRAM;
    end else if (a32 <= SMD_VGA_END) begin
      map_dst = bridge_control_vga ? SMD_DST_AGP : SMD_DST_PCI;
    end else if (a32 <= SMD_EXP_END) begin
      map_dst = exp_dram ? SMD_DST_DRAM : SMD_DST_PCI;
    end else if (a32 <= SMD_EBIOS_END) begin
      map_dst = ebios_dram ? SMD_DST_DRAM : SMD_DST_PCI;
    end else if (a32 <= SMD_SBIOS_END) begin
      map_dst = sbios_dram ? SMD_DST_DRAM : SMD_DST_PCI;
    end else if (below_tom) begin
      // the hole only steers to PCI; the address is never shifted upward
      map_dst = hole_hit ? SMD_DST_PCI : SMD_DST_DRAM;
    end else if (a32 >= SMD_HBIOS_BASE) begin
      map_dst = SMD_DST_PCI;
    end else if (a32 >= SMD_GAP_BASE) begin
      map_dst = SMD_DST_PCI;
    end else if (a32[31:SMD_GRAN_LSB] == SMD_IOAPIC_BASE[31:SMD_GRAN_LSB]) begin
      map_dst = SMD_DST_PCI;
    end else if (agp_hit) begin
      map_dst = SMD_DST_AGP;
    end else if (apert_hit) begin
      map_dst = SMD_DST_DRAM;
    end
  end

  // source-dependent claim and termination
  always_comb begin
    rsp_nxt           = '0;
    rsp_nxt.addr      = a32;
    rsp_nxt.dest      = map_dst;
    if (req.dac) begin
      rsp_nxt.dest = SMD_DST_NONE;
    end else if (req.addr >= SMD_4G_BASE) begin
      rsp_nxt.dest = (req.src == SMD_SRC_HOST) ? SMD_DST_TERM : SMD_DST_NONE;
      rsp_nxt.discard   = req.write;
      rsp_nxt.read_zero = !req.write;
    end else if (req.src == SMD_SRC_PCI && map_dst == SMD_DST_AGP && !req.write) begin
      rsp_nxt.dest = SMD_DST_NONE;
    end else if (req.src == SMD_SRC_PCI && map_dst == SMD_DST_PCI) begin
      // a PCI master's own range is never claimed back
      rsp_nxt.dest = SMD_DST_NONE;
    end else if (req.src == SMD_SRC_AGP && map_dst != SMD_DST_DRAM) begin
      rsp_nxt.dest = SMD_DST_NONE;
    end
  end

  // decision register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp <= rsp_nxt;
      end
    end
  end

  // status: last decision, readable by software
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last_dest_r <= SMD_DST_NONE;
      last_zero_r <= 1'b0;
    end else if (req_valid) begin
      last_dest_r <= rsp_nxt.dest;
      last_zero_r <= rsp_nxt.read_zero;
    end
  end

endmodule // smd_decoder

// file: sim/smd_decoder_asserts.sv
// checker: port assertions for the memory address decoder
`timescale 1ns/1ps
module smd_decoder_asserts
  import smd_pkg::*;
#(
  parameter logic [11:0] TOM_RST = 12'h010
) (
  // clock, reset and register port
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic [7:0]        reg_addr,
  input wire logic [31:0]       reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [31:0]       reg_rdata,
  // decode port
  input wire logic              req_valid,
  input wire smd_pkg::smd_req_t req,
  input wire logic              rsp_valid,
  input wire smd_pkg::smd_rsp_t rsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_host; req_valid && !req.dac && req.src == SMD_SRC_HOST; endsequence
  sequence s_high; s_host ##0 req.addr[35:32] != 4'h0; endsequence
  sequence s_low; s_host ##0 req.addr[35:32] == 4'h0; endsequence
  a_rsp_follows: assert property (req_valid |=> rsp_valid)
    else $error("no response one cycle after a request");
  a_rsp_idle_held: assert property (!req_valid |=> !rsp_valid && $stable(rsp))
    else $error("response moved without a request");
  a_high_term: assert property (s_high |=> rsp.dest == SMD_DST_TERM)
    else $error("access above 4 GB not terminated");
  a_high_discard: assert property (s_high ##0 req.write |=>
    rsp.discard && !rsp.read_zero)
    else $error("high write data not discarded");
  a_high_zero: assert property (s_high ##0 !req.write |=> rsp.read_zero && !rsp.discard)
    else $error("high read not answered with zeros");
  a_dac_refused: assert property (req_valid && req.dac |=> rsp.dest == SMD_DST_NONE)
    else $error("dual address cycle was claimed");
  a_dos_dram: assert property (s_low ##0 req.addr[31:0] <= 32'h0007_FFFF |=>
    rsp.dest == SMD_DST_DRAM)
    else $error("low DOS area not sent to DRAM");
  a_video_route: assert property (s_low ##0 req.addr[31:17] == 15'h0005 |=>
    rsp.dest inside {SMD_DST_PCI, SMD_DST_AGP})
    else $error("video range not sent to PCI or AGP");
  a_gap_pci: assert property (s_low ##0 req.addr[31:0] >= 32'hFEC0_FFFF |=>
    rsp.dest == SMD_DST_PCI)
    else $error("gap or high firmware not sent to PCI");
  a_addr_kept: assert property (req_valid |=> rsp.addr == $past(req.addr[31:0]))
    else $error("address was remapped");
endmodule // smd_decoder_asserts

bind smd_decoder smd_decoder_asserts #(.TOM_RST(TOM_RST)) u_chk (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req(req), .rsp_valid(rsp_valid), .rsp(rsp));

// file: sim/smd_host_side.sv
// far-side model: data the host bus returns for a decoded access
`timescale 1ns/1ps
module smd_host_side
  import smd_pkg::*;
(
  // clock
  input wire logic              clk,
  // decoder result
  input wire logic              rsp_valid,
  input wire smd_pkg::smd_rsp_t rsp,
  // host data
  output logic [31:0]           host_rdata
);
  logic [31:0] idle_r = 32'h5A5A_A5A5;
  // released bus toggles every cycle so stale data never looks valid
  always_ff @(posedge clk) begin
    idle_r <= ~idle_r;
  end
  always_comb begin
    host_rdata = idle_r;
    if (rsp_valid && rsp.read_zero) begin
      host_rdata = 32'h0;
    end else if (rsp_valid) begin
      host_rdata = {rsp.addr[15:0], rsp.addr[31:16]};
    end
  end
endmodule // smd_host_side

// file: sim/smd_decoder_bench.sv
// bench: self-checking test of the memory address decoder
`timescale 1ns/1ps
module smd_decoder_bench;
  import smd_pkg::*;
  localparam logic [11:0] TOM_V = 12'h010;
  // random values stay legal: small top of memory, windows well below FEC
  localparam logic [31:0] CON [7] = '{32'h7, 32'h3FF, 32'h0FFF_0FFF, 32'h07FF_07FF,
    32'h07FF_07FF, 32'h000F_07FF, 32'h03FF_FFFF};
  localparam logic [31:0] FIX [7] = '{32'h7, 32'h100, 32'h005F_0050, 32'h020F_0200,
    32'h030F_0300, 32'h0003_0400, 32'h02AA_AAAA};
  localparam logic [35:0] TAB [20] = '{36'h0_0007_FFFF, 36'h0_0008_0000, 36'h0_0009_FFFF,
    36'h0_000A_0000, 36'h0_000B_FFFF, 36'h0_000C_0000, 36'h0_000D_FFFF, 36'h0_000E_0000,
    36'h0_000F_0000, 36'h0_0010_0000, 36'h0_0550_0000, 36'h0_2000_0000, 36'h0_30FF_FFFF,
    36'h0_4030_0000, 36'h0_1000_0000, 36'h0_FEC0_0000, 36'h0_FEC0_FFFF, 36'h0_FFE0_0000,
    36'h1_0000_0000, 36'hF_FFFF_FFFF};
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        req_valid = 1'b0;
  smd_req_t    req = '0;
  logic        rsp_valid;
  smd_rsp_t    rsp;
  logic [31:0] host_rdata;
  logic [31:0] sh [7];
  logic [31:0] rnd = 32'h4E0E;
  int          fails = 0;
  int          n_checks = 0;
  always #5 clk = ~clk;
  smd_decoder #(.TOM_RST(TOM_V)) u_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp));
  smd_host_side u_host (.clk(clk), .rsp_valid(rsp_valid), .rsp(rsp), .host_rdata(host_rdata));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic inwin(input logic [31:0] r, input logic [11:0] g);
    return g >= r[11:0] && g <= r[27:16];
  endfunction
  function automatic smd_dst_t route(input logic [31:0] a, input logic w);
    logic [11:0] g;
    int i;
    g = a[31:20];
    i = a < SMD_EBIOS_BASE ? 2 * a[16:14] : (a < 32'h000F_0000 ? 16 + 2 * a[15:14] : 24);
    if (a <= SMD_DOS_LOW_END) return SMD_DST_DRAM;
    if (a <= SMD_DOS_HI_END) return sh[0][0] ? SMD_DST_PCI : SMD_DST_DRAM;
    if (a <= SMD_VGA_END) return sh[0][1] ? SMD_DST_AGP : SMD_DST_PCI;
    if (a <= SMD_SBIOS_END)
      return sh[6][i + w] ? SMD_DST_DRAM : SMD_DST_PCI;
    if (a >= SMD_GAP_BASE || g == 12'hFEC) return SMD_DST_PCI;
    if (g < sh[1][11:0]) return sh[0][2] && inwin(sh[2], g) ? SMD_DST_PCI : SMD_DST_DRAM;
    if (inwin(sh[3], g) || inwin(sh[4], g)) return SMD_DST_AGP;
    if (((g ^ sh[5][11:0]) & ~sh[5][27:16]) == 12'h000) return SMD_DST_DRAM;
    return SMD_DST_PCI;
  endfunction
  function automatic smd_dst_t exp_dst(logic [35:0] a, logic w, smd_src_t s, logic d);
    smd_dst_t r;
    r = a[35:32] != 4'h0 ? SMD_DST_TERM : route(a[31:0], w);
    if (d || s == SMD_SRC_HOST) return d ? SMD_DST_NONE : r;
    if (r == SMD_DST_TERM || r == SMD_DST_PCI) return SMD_DST_NONE;
    if (s == SMD_SRC_AGP && r != SMD_DST_DRAM) return SMD_DST_NONE;
    return (r == SMD_DST_AGP && !w) ? SMD_DST_NONE : r;
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic prog;
    for (int i = 0; i < 7; i++) wr(8'(i * 4), sh[i]);
    for (int i = 0; i < 7; i++) rd(8'(i * 4), sh[i]);
  endtask
  task automatic rst_chk;
    sh = '{default: 32'h0};
    sh[1] = {20'h0, TOM_V};
    for (int i = 0; i < 7; i++) rd(8'(i * 4), sh[i]);
  endtask
  task automatic dec(input logic [35:0] a, input logic w, input smd_src_t s, input logic d);
    smd_dst_t e;
    logic hi;
    e = exp_dst(a, w, s, d);
    // every high access is flagged, claimed or not; a dual address cycle never is
    hi = !d && a[35:32] != 4'h0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, src: s, dac: d};
    @(posedge clk);
    req_valid <= 1'b0;
    @(negedge clk);
    chk("rsp_valid", 32'h1, {31'h0, rsp_valid});
    chk("dest", {29'h0, e}, {29'h0, rsp.dest});
    chk("addr", a[31:0], rsp.addr);
    chk("read_zero", {31'h0, hi & ~w}, {31'h0, rsp.read_zero});
    chk("discard", {31'h0, hi & w}, {31'h0, rsp.discard});
    if (hi && !w) chk("host_rdata", 32'h0, host_rdata);
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    logic [35:0] a;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    rst_chk();
    for (int c = 0; c < 2; c++) begin
      if (c == 1) begin
        sh = FIX;
        prog();
      end
      for (int i = 0; i < 20; i++)
        for (int k = 0; k < 6; k++) dec(TAB[i], k[0], smd_src_t'(k / 2), 1'b0);
    end
    dec(36'h1_0000_0000, 1'b0, SMD_SRC_PCI, 1'b1);
    dec(36'h0_0010_0000, 1'b1, SMD_SRC_HOST, 1'b1);
    dec(36'h1_0000_0000, 1'b0, SMD_SRC_HOST, 1'b0);
    rd(SMD_REG_STATUS, {28'h0, 1'b1, SMD_DST_TERM});
    wr(SMD_REG_STATUS, 32'hFFFF_FFFF);
    rd(SMD_REG_STATUS, {28'h0, 1'b1, SMD_DST_TERM});
    rd(8'h20, 32'h0);
    for (int n = 0; n < 300; n++) begin
      if (n % 30 == 0) begin
        for (int i = 0; i < 7; i++) begin
          rnd = lfsr(rnd);
          sh[i] = rnd & CON[i];
        end
        prog();
      end
      rnd = lfsr(rnd);
      a = {rnd[2:0] == 3'h0 ? rnd[7:4] : 4'h0, rnd[1] ? rnd : {12'h000, rnd[31:12]}};
      dec(a, rnd[10], rnd[9:8] == 2'h3 ? SMD_SRC_HOST : smd_src_t'(rnd[9:8]),
        rnd[15:11] == 5'h00);
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rst_chk();
    dec(36'h0_000F_0000, 1'b0, SMD_SRC_HOST, 1'b0);
    close_out();
  end
endmodule // smd_decoder_bench
